// File: dual_uart.sv
// Two serial channels sharing one pin pair, with rate generators, routing and transmit FIFOs
`include "dual_uart_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tx_word_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input  wire logic             clock_in,      // CPU clock
   input  wire logic             arst_n_in,     // Async reset, active low
   input  wire logic             in_valid_in,   // Word offered
   output logic                  in_ready_out,  // Room for a word
   input  wire logic [WIDTH-1:0] in_data_in,    // Word in
   output logic                  out_valid_out, // Word available
   input  wire logic             out_ready_in,  // Consumer takes word
   output logic [WIDTH-1:0]      out_data_out   // Head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_q;
   logic [AW:0]      rd_ptr_q;
   logic             push;
   logic             pop;

   assign in_ready_out  = (wr_ptr_q[AW-1:0] != rd_ptr_q[AW-1:0]) || (wr_ptr_q[AW] == rd_ptr_q[AW]);
   assign out_valid_out = wr_ptr_q != rd_ptr_q;
   assign out_data_out  = mem[rd_ptr_q[AW-1:0]];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   always_ff @(posedge clock_in) begin
      if (push) begin
         mem[wr_ptr_q[AW-1:0]] <= in_data_in;
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
      end
   end
endmodule : tx_word_fifo

module dual_uart #(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic        clock_in,                    // CPU clock, 100 MHz
   input  wire logic        arst_n_in,                   // Async reset, active low
   input  wire logic [15:0] sfr_addr_in,                 // Register address
   input  wire logic        sfr_wr_in,                   // Register write strobe
   input  wire logic        sfr_rd_in,                   // Register read strobe
   input  wire logic [7:0]  sfr_wdata_in,                // Write data
   output logic      [7:0]  sfr_rdata_out,               // Read data, one cycle after strobe
   input  wire logic [7:0]  timer_one_high_byte_in,      // Timer 1 reload byte
   input  wire logic        rx_pin_in,                   // Serial receive pin
   output logic             tx_pin_out,                  // Serial transmit pin
   output logic             channel_zero_irq_out,        // Channel zero rx or tx pending
   output logic             channel_one_irq_out,         // Channel one rx or tx pending
   output logic      [15:0] irq_vector_out,              // Vector of pending serial request
   output logic      [1:0]  tx_fifo_ready_out,           // Transmit FIFO has room, per channel
   output logic             chip_power_down_request_out  // Power down bit
);
   logic [7:0] power_and_baud_double_control_q;
   logic [7:0] baud_source_control_q;
   logic [7:0] serial_pin_routing_control_q;
   logic       rx_meta_q;
   logic       rx_sync_q;
   logic       rx_target;
   logic [7:0] rdata_d;

   function automatic logic [15:0] tick_period(
      input logic       is_ch1,
      input logic [1:0] mode,
      input logic       dbl,
      input logic       use_gen,
      input logic [7:0] timer_high,
      input logic [9:0] rel
   );
      logic [15:0] p;
      p = `FIXED_RATE_TICK;
      if (is_ch1) begin
         p = (16'h0400 - {6'h00, rel}) << `CH1_GEN_TICK_SHIFT;
      end else if (mode == 2'b10) begin
         p = `FIXED_RATE_TICK;
      end else if (use_gen) begin
         p = (16'h0400 - {6'h00, rel}) << `CH0_GEN_TICK_SHIFT;
      end else begin
         p = (16'h0100 - {8'h00, timer_high}) * `TIMER_ONE_TICK_MULT;
      end
      if (!is_ch1 && dbl) begin
         p = p >> 1;
      end
      return p;
   endfunction : tick_period

   // Global control registers
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         power_and_baud_double_control_q <= `RESET_BYTE;
         baud_source_control_q           <= `RESET_BYTE;
         serial_pin_routing_control_q    <= `RESET_BYTE;
      end else if (sfr_wr_in) begin
         if (sfr_addr_in == `ADDR_POWER_AND_BAUD_DOUBLE) begin
            power_and_baud_double_control_q <= sfr_wdata_in;
         end
         if (sfr_addr_in == `ADDR_BAUD_SOURCE_CONTROL) begin
            baud_source_control_q <= {sfr_wdata_in[7], 7'h00};
         end
         if (sfr_addr_in == `ADDR_SERIAL_PIN_ROUTING) begin
            serial_pin_routing_control_q <= {sfr_wdata_in[7], 5'h00, sfr_wdata_in[1:0]};
         end
      end
   end

   // Pin is asynchronous to the CPU clock
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
      end else begin
         rx_meta_q <= rx_pin_in;
         rx_sync_q <= rx_meta_q;
      end
   end

   // In loopback the pins are tied outside, so the pin feeds the other channel
   assign rx_target = serial_pin_routing_control_q[`BIT_PIN_SELECT]
                      ^ serial_pin_routing_control_q[`BIT_LOOPBACK];

   for (genvar c = 0; c < 2; c++) begin : ch
      localparam logic [15:0] CON_A = (c == 1) ? `ADDR_CH1_CONTROL     : `ADDR_CH0_CONTROL;
      localparam logic [15:0] BUF_A = (c == 1) ? `ADDR_CH1_DATA        : `ADDR_CH0_DATA;
      localparam logic [15:0] RLL_A = (c == 1) ? `ADDR_CH1_RELOAD_LOW  : `ADDR_CH0_RELOAD_LOW;
      localparam logic [15:0] RLH_A = (c == 1) ? `ADDR_CH1_RELOAD_HIGH : `ADDR_CH0_RELOAD_HIGH;

      logic [7:0]                  con_q;
      logic [7:0]                  buf_q;
      logic [7:0]                  rell_q;
      logic [1:0]                  relh_q;
      logic                        nine;
      logic                        active;
      logic [15:0]                 div_q;
      logic                        tick;
      logic                        line_in;
      logic                        fifo_in_ready;
      logic                        fifo_out_valid;
      logic                        fifo_pop;
      dual_uart_pkg::tx_word_s     fifo_word_in;
      dual_uart_pkg::tx_word_s     fifo_word_out;
      dual_uart_pkg::tx_state_e    tx_state_q;
      logic [10:0]                 tx_shift_q;
      logic [3:0]                  tx_bits_q;
      logic [3:0]                  tx_sub_q;
      logic                        tx_done;
      dual_uart_pkg::rx_state_e    rx_state_q;
      logic [3:0]                  rx_sub_q;
      logic [3:0]                  rx_bits_q;
      logic [9:0]                  rx_shift_q;
      logic [9:0]                  rx_next;
      logic                        rx_prev_q;
      logic                        rx_last;
      logic                        rx_ninth;
      logic                        rx_done;

      if (c == 1) begin : fmt1
         assign nine   = !con_q[`BIT_MODE_HI];
         assign active = 1'b1;
      end else begin : fmt0
         assign nine   = con_q[`BIT_MODE_HI];
         assign active = con_q[`BIT_MODE_HI] || con_q[`BIT_MODE_LO];
      end

      assign line_in = (rx_target == (c == 1)) ? rx_sync_q : 1'b1;

      // Oversample tick: 16 per bit, so at 100 MHz reloads cover about 1526 to 3125000 baud
      always_ff @(posedge clock_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            div_q <= 16'h0000;
         end else if (div_q == 16'h0000) begin
            div_q <= tick_period(c == 1, con_q[7:6],
                                 power_and_baud_double_control_q[`BIT_BAUD_DOUBLE],
                                 baud_source_control_q[`BIT_BAUD_SOURCE_SELECT],
                                 timer_one_high_byte_in, {relh_q, rell_q}) - 16'h0001;
         end else begin
            div_q <= div_q - 16'h0001;
         end
      end
      assign tick = div_q == 16'h0000;

      always_ff @(posedge clock_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            rell_q <= `RESET_BYTE;
            relh_q <= 2'b00;
         end else if (sfr_wr_in) begin
            if (sfr_addr_in == RLL_A) begin
               rell_q <= sfr_wdata_in;
            end
            if (sfr_addr_in == RLH_A) begin
               relh_q <= sfr_wdata_in[1:0];
            end
         end
      end

      // Control register: hardware set after the software write, so a set wins
      always_ff @(posedge clock_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            con_q <= `RESET_BYTE;
         end else begin
            if (sfr_wr_in && sfr_addr_in == CON_A) begin
               con_q <= (c == 1) ? (sfr_wdata_in & 8'hbf) : sfr_wdata_in;
            end
            if (tx_done) begin
               con_q[`BIT_TX_FLAG] <= 1'b1;
            end
            if (rx_done) begin
               con_q[`BIT_RX_FLAG]  <= 1'b1;
               con_q[`BIT_RX_NINTH] <= rx_ninth;
            end
         end
      end

      assign fifo_word_in.ninth = con_q[`BIT_TX_NINTH];
      assign fifo_word_in.data  = sfr_wdata_in;
      assign fifo_pop           = (tx_state_q == dual_uart_pkg::TX_IDLE) && active && tick;

      tx_word_fifo #(
         .WIDTH ($bits(dual_uart_pkg::tx_word_s)),
         .DEPTH (FIFO_DEPTH)
      ) tx_fifo (
         .clock_in      (clock_in),
         .arst_n_in     (arst_n_in),
         .in_valid_in   (sfr_wr_in && sfr_addr_in == BUF_A),
         .in_ready_out  (fifo_in_ready),
         .in_data_in    (fifo_word_in),
         .out_valid_out (fifo_out_valid),
         .out_ready_in  (fifo_pop),
         .out_data_out  (fifo_word_out)
      );

      // Transmitter: shift register refills with ones so the line rests high
      assign tx_done = (tx_state_q == dual_uart_pkg::TX_SEND) && tick
                       && (tx_sub_q == `LAST_TICK) && (tx_bits_q == 4'h1);
      always_ff @(posedge clock_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            tx_state_q <= dual_uart_pkg::TX_IDLE;
            tx_shift_q <= 11'h7ff;
            tx_bits_q  <= 4'h0;
            tx_sub_q   <= 4'h0;
         end else if (tx_state_q == dual_uart_pkg::TX_IDLE) begin
            if (fifo_pop && fifo_out_valid) begin
               tx_state_q <= dual_uart_pkg::TX_SEND;
               tx_shift_q <= {1'b1, nine ? fifo_word_out.ninth : 1'b1,
                              fifo_word_out.data, 1'b0};
               tx_bits_q  <= nine ? 4'hb : 4'ha;
               tx_sub_q   <= 4'h0;
            end
         end else if (tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == `LAST_TICK) begin
               tx_shift_q <= {1'b1, tx_shift_q[10:1]};
               tx_bits_q  <= tx_bits_q - 4'h1;
               if (tx_bits_q == 4'h1) begin
                  tx_state_q <= dual_uart_pkg::TX_IDLE;
               end
            end
         end
      end

      // Receiver: start on a falling edge, check it at mid bit, then sample every 16 ticks
      assign rx_next  = {line_in, rx_shift_q[9:1]};
      assign rx_last  = rx_bits_q == (nine ? 4'h9 : 4'h8);
      assign rx_ninth = nine ? rx_next[8] : rx_next[9];
      assign rx_done  = (rx_state_q == dual_uart_pkg::RX_DATA) && tick
                        && (rx_sub_q == `LAST_TICK) && rx_last
                        && !con_q[`BIT_RX_FLAG]
                        && (!con_q[`BIT_MULTIPROC] || rx_ninth);
      always_ff @(posedge clock_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            rx_state_q <= dual_uart_pkg::RX_IDLE;
            rx_sub_q   <= 4'h0;
            rx_bits_q  <= 4'h0;
            rx_shift_q <= 10'h000;
            rx_prev_q  <= 1'b1;
         end else begin
            rx_prev_q <= line_in;
            unique case (rx_state_q)
               dual_uart_pkg::RX_IDLE: begin
                  if (active && con_q[`BIT_RX_ENABLE] && rx_prev_q && !line_in) begin
                     rx_state_q <= dual_uart_pkg::RX_START;
                     rx_sub_q   <= 4'h0;
                  end
               end
               dual_uart_pkg::RX_START: begin
                  if (tick) begin
                     rx_sub_q <= rx_sub_q + 4'h1;
                     if (rx_sub_q == `SAMPLE_TICK) begin
                        rx_state_q <= line_in ? dual_uart_pkg::RX_IDLE
                                              : dual_uart_pkg::RX_DATA;
                        rx_sub_q   <= 4'h0;
                        rx_bits_q  <= 4'h0;
                     end
                  end
               end
               dual_uart_pkg::RX_DATA: begin
                  if (tick) begin
                     rx_sub_q <= rx_sub_q + 4'h1;
                     if (rx_sub_q == `LAST_TICK) begin
                        rx_shift_q <= rx_next;
                        rx_bits_q  <= rx_bits_q + 4'h1;
                        if (rx_last) begin
                           rx_state_q <= dual_uart_pkg::RX_IDLE;
                        end
                     end
                  end
               end
            endcase
         end
      end

      always_ff @(posedge clock_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            buf_q <= `RESET_BYTE;
         end else if (rx_done) begin
            buf_q <= nine ? rx_next[7:0] : rx_next[8:1];
         end
      end
   end

   always_comb begin
      unique case (sfr_addr_in)
         `ADDR_POWER_AND_BAUD_DOUBLE: rdata_d = power_and_baud_double_control_q;
         `ADDR_BAUD_SOURCE_CONTROL:   rdata_d = baud_source_control_q;
         `ADDR_SERIAL_PIN_ROUTING:    rdata_d = serial_pin_routing_control_q;
         `ADDR_CH0_CONTROL:           rdata_d = ch[0].con_q;
         `ADDR_CH0_DATA:              rdata_d = ch[0].buf_q;
         `ADDR_CH0_RELOAD_LOW:        rdata_d = ch[0].rell_q;
         `ADDR_CH0_RELOAD_HIGH:       rdata_d = {6'h00, ch[0].relh_q};
         `ADDR_CH1_CONTROL:           rdata_d = ch[1].con_q;
         `ADDR_CH1_DATA:              rdata_d = ch[1].buf_q;
         `ADDR_CH1_RELOAD_LOW:        rdata_d = ch[1].rell_q;
         `ADDR_CH1_RELOAD_HIGH:       rdata_d = {6'h00, ch[1].relh_q};
         default:                     rdata_d = 8'h00;
      endcase
   end

   // All outputs registered; pin and flags lag their sources by one cycle
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sfr_rdata_out               <= 8'h00;
         tx_pin_out                  <= 1'b1;
         channel_zero_irq_out        <= 1'b0;
         channel_one_irq_out         <= 1'b0;
         irq_vector_out              <= `VECTOR_NONE;
         tx_fifo_ready_out           <= 2'b00;
         chip_power_down_request_out <= 1'b0;
      end else begin
         if (sfr_rd_in) begin
            sfr_rdata_out <= rdata_d;
         end
         tx_pin_out <= serial_pin_routing_control_q[`BIT_PIN_SELECT]
                       ? ch[1].tx_shift_q[0] : ch[0].tx_shift_q[0];
         channel_zero_irq_out <= ch[0].con_q[`BIT_TX_FLAG] | ch[0].con_q[`BIT_RX_FLAG];
         channel_one_irq_out  <= ch[1].con_q[`BIT_TX_FLAG] | ch[1].con_q[`BIT_RX_FLAG];
         // Channel one sits in the higher polling group, so it is reported first
         if (ch[1].con_q[`BIT_TX_FLAG] | ch[1].con_q[`BIT_RX_FLAG]) begin
            irq_vector_out <= `VECTOR_CH1;
         end else if (ch[0].con_q[`BIT_TX_FLAG] | ch[0].con_q[`BIT_RX_FLAG]) begin
            irq_vector_out <= `VECTOR_CH0;
         end else begin
            irq_vector_out <= `VECTOR_NONE;
         end
         tx_fifo_ready_out           <= {ch[1].fifo_in_ready, ch[0].fifo_in_ready};
         chip_power_down_request_out <= serial_pin_routing_control_q[`BIT_POWER_DOWN];
      end
   end
endmodule : dual_uart

`default_nettype wire

// File: dual_uart_defs.svh
// Register addresses, field positions, reset values and rate constants for the dual serial block
`ifndef DUAL_UART_DEFS_SVH
`define DUAL_UART_DEFS_SVH

`define ADDR_POWER_AND_BAUD_DOUBLE 16'h0087
`define ADDR_BAUD_SOURCE_CONTROL   16'h00d8
`define ADDR_SERIAL_PIN_ROUTING    16'hfff1
`define ADDR_CH0_CONTROL           16'h0098
`define ADDR_CH0_DATA              16'h0099
`define ADDR_CH0_RELOAD_LOW        16'h00aa
`define ADDR_CH0_RELOAD_HIGH       16'h00ba
`define ADDR_CH1_CONTROL           16'h009b
`define ADDR_CH1_DATA              16'h009c
`define ADDR_CH1_RELOAD_LOW        16'h009d
`define ADDR_CH1_RELOAD_HIGH       16'h00bb

`define RESET_BYTE                 8'h00

`define BIT_BAUD_DOUBLE            7
`define BIT_BAUD_SOURCE_SELECT     7
`define BIT_POWER_DOWN             7
`define BIT_LOOPBACK               1
`define BIT_PIN_SELECT             0
`define BIT_MODE_HI                7
`define BIT_MODE_LO                6
`define BIT_MULTIPROC              5
`define BIT_RX_ENABLE              4
`define BIT_TX_NINTH               3
`define BIT_RX_NINTH               2
`define BIT_TX_FLAG                1
`define BIT_RX_FLAG                0

`define VECTOR_CH0                 16'h0023
`define VECTOR_CH1                 16'h0083
`define VECTOR_NONE                16'h0000

`define CPU_CLOCK_HZ               100000000
`define OVERSAMPLE                 16
`define SAMPLE_TICK                4'h7
`define LAST_TICK                  4'hf
`define TIMER_ONE_TICK_MULT        16'd24
`define CH0_GEN_TICK_SHIFT         2
`define CH1_GEN_TICK_SHIFT         1
`define FIXED_RATE_TICK            16'h0004

`endif

// File: dual_uart_pkg.sv
// Types shared by the dual serial block
package dual_uart_pkg;
   typedef struct packed {
      logic       ninth;
      logic [7:0] data;
   } tx_word_s;

   typedef enum logic [1:0] {
      RX_IDLE,
      RX_START,
      RX_DATA
   } rx_state_e;

   typedef enum logic {
      TX_IDLE,
      TX_SEND
   } tx_state_e;
endpackage : dual_uart_pkg

// File: dual_uart_props.sv
// Port checker for the dual serial block
`timescale 1ns/1ps
`default_nettype none
module dual_uart_props (
   input wire logic        clock_in,             // Clock
   input wire logic        arst_n_in,            // Reset
   input wire logic [15:0] sfr_addr_in,          // Address
   input wire logic        sfr_wr_in,            // Write
   input wire logic        sfr_rd_in,            // Read
   input wire logic [7:0]  sfr_rdata_out,        // Read data
   input wire logic        tx_pin_out,           // Transmit pin
   input wire logic        channel_zero_irq_out, // Channel zero
   input wire logic        channel_one_irq_out,  // Channel one
   input wire logic [15:0] irq_vector_out        // Vector
);
   logic [7:0] low_run_q;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);
   // Saturates, so a long break never wraps below one bit time
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in)
         low_run_q <= 8'h00;
      else if (tx_pin_out)
         low_run_q <= 8'h00;
      else if (low_run_q != 8'hff)
         low_run_q <= low_run_q + 8'h01;
   end
   sequence s_pending(irq, logic [15:0] a);
      !(sfr_wr_in && sfr_addr_in == a) ##1 (irq && !(sfr_wr_in && sfr_addr_in == a));
   endsequence
   property p_ch0_hold;
      s_pending(channel_zero_irq_out, 16'h0098) |=> ##1 channel_zero_irq_out;
   endproperty
   property p_ch1_hold;
      s_pending(channel_one_irq_out, 16'h009b) |=> ##1 channel_one_irq_out;
   endproperty
   property p_vec_one;
      channel_one_irq_out |-> irq_vector_out == 16'h0083;
   endproperty
   property p_vec_zero;
      channel_zero_irq_out && !channel_one_irq_out |-> irq_vector_out == 16'h0023;
   endproperty
   property p_vec_none;
      !channel_zero_irq_out && !channel_one_irq_out |-> irq_vector_out == 16'h0000;
   endproperty
   property p_rdata_hold;
      !sfr_rd_in |=> $stable(sfr_rdata_out);
   endproperty
   property p_src_reserved;
      sfr_rd_in && sfr_addr_in == 16'h00d8 |=> sfr_rdata_out[6:0] == 7'h00;
   endproperty
   property p_min_bit;
      $rose(tx_pin_out) |-> low_run_q >= 8'h20;
   endproperty
   a_ch0_hold: assert property (p_ch0_hold)
      else $error("channel zero request lost");
   a_ch1_hold: assert property (p_ch1_hold)
      else $error("channel one request lost");
   a_vec_one: assert property (p_vec_one)
      else $error("channel one vector wrong");
   a_vec_zero: assert property (p_vec_zero)
      else $error("channel zero vector wrong");
   a_vec_none: assert property (p_vec_none)
      else $error("idle vector wrong");
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved");
   a_src_reserved: assert property (p_src_reserved)
      else $error("source reserved bits set");
   a_min_bit: assert property (p_min_bit)
      else $error("low pulse too short");
endmodule : dual_uart_props
bind dual_uart dual_uart_props i_props (.clock_in(clock_in), .arst_n_in(arst_n_in), .sfr_addr_in(sfr_addr_in),
   .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out), .tx_pin_out(tx_pin_out),
   .channel_zero_irq_out(channel_zero_irq_out), .channel_one_irq_out(channel_one_irq_out),
   .irq_vector_out(irq_vector_out));
`default_nettype wire

// File: serial_host_model.sv
// Far-end host: captures device frames and sends frames to it
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
   input  wire logic        clock_in,      // Clock
   input  wire logic        line_in,       // Device transmit pin
   input  wire logic [15:0] bit_cycles_in, // Clocks per bit
   input  wire logic        nine_in,       // Nine-bit frames
   output logic             line_out,      // Device receive pin
   output logic      [9:0]  got_out        // Bits after start
);
   initial begin
      line_out = 1'b1;
      got_out = 10'h000;
      forever begin
         @(negedge line_in);
         repeat (bit_cycles_in / 2) @(posedge clock_in);
         got_out = 10'h000;
         for (int i = 0; i < (nine_in ? 10 : 9); i++) begin
            repeat (bit_cycles_in) @(posedge clock_in);
            got_out[i] = line_in;
         end
      end
   end
   task automatic send_word(input logic [8:0] w);
      logic [10:0] frame;
      frame = nine_in ? {1'b1, w, 1'b0} : {2'b11, w[7:0], 1'b0};
      for (int i = 0; i < 11; i++) begin
         line_out <= frame[i];
         repeat (bit_cycles_in) @(posedge clock_in);
      end
   endtask : send_word
endmodule : serial_host_model
`default_nettype wire

// File: tb_dual_uart.sv
// Self-checking bench for the dual serial block
`timescale 1ns/1ps
`default_nettype none
`include "dual_uart_defs.svh"
module tb_dual_uart;
   logic        clock_in, arst_n_in, sfr_wr_in, sfr_rd_in, loop_q, tx_pin, host_tx, irq0, irq1, nine, c, pd;
   logic [15:0] sfr_addr_in, bits, vec;
   logic [7:0]  sfr_wdata_in, rdata, timer_hi;
   logic [1:0]  fifo_rdy;
   logic [9:0]  got;
   int          bad_count, comparisons;
   logic [7:0]  ctrl_t [5] = '{8'h88, 8'h80, 8'h40, 8'hc8, 8'h08};
   logic [7:0]  src_t [5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
   logic [7:0]  dbl_t [5] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h00};
   logic [7:0]  rel_t [5] = '{8'hff, 8'hff, 8'hff, 8'hfe, 8'hff};
   logic [15:0] bits_t [5] = '{16'h0020, 16'h0040, 16'h0180, 16'h0080, 16'h0020};
   dual_uart #(.FIFO_DEPTH(4)) i_dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .sfr_addr_in(sfr_addr_in),
      .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(rdata),
      .timer_one_high_byte_in(timer_hi), .rx_pin_in(loop_q ? tx_pin : host_tx), .tx_pin_out(tx_pin),
      .channel_zero_irq_out(irq0), .channel_one_irq_out(irq1), .irq_vector_out(vec),
      .tx_fifo_ready_out(fifo_rdy), .chip_power_down_request_out(pd));
   serial_host_model i_host (.clock_in(clock_in), .line_in(tx_pin), .bit_cycles_in(bits), .nine_in(nine),
      .line_out(host_tx), .got_out(got));
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      sfr_addr_in <= a;
      sfr_wdata_in <= d;
      sfr_wr_in <= 1'b1;
      @(posedge clock_in);
      sfr_wr_in <= 1'b0;
      @(posedge clock_in);
   endtask : wr
   task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
      sfr_addr_in <= a;
      sfr_rd_in <= 1'b1;
      @(posedge clock_in);
      sfr_rd_in <= 1'b0;
      @(posedge clock_in);
      check(what, {8'h00, rdata}, {8'h00, exp});
   endtask : rd_chk
   task automatic wait_on(input int sel);
      int t;
      t = 0;
      while ((sel == 0 ? irq0 : sel == 1 ? irq1 : fifo_rdy[0]) !== 1'b1) begin
         @(posedge clock_in);
         t++;
         if (t > 8000) begin
            bad_count++;
            summarize();
         end
      end
   endtask : wait_on
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   initial begin
      arst_n_in = 1'b0;
      sfr_wr_in = 1'b0;
      sfr_rd_in = 1'b0;
      sfr_addr_in = 16'h0000;
      sfr_wdata_in = 8'h00;
      timer_hi = 8'hfe;
      loop_q = 1'b0;
      bits = 16'h0020;
      nine = 1'b0;
      repeat (20) @(posedge clock_in);
      arst_n_in <= 1'b1;
      rd_chk("double", `ADDR_POWER_AND_BAUD_DOUBLE, 8'h00);
      check("fifo ready", {14'h0000, fifo_rdy}, 16'h0003);
      rd_chk("source", `ADDR_BAUD_SOURCE_CONTROL, 8'h00);
      rd_chk("routing", `ADDR_SERIAL_PIN_ROUTING, 8'h00);
      rd_chk("unmapped", 16'h0001, 8'h00);
      wr(`ADDR_BAUD_SOURCE_CONTROL, 8'hff);
      rd_chk("source", `ADDR_BAUD_SOURCE_CONTROL, 8'h80);
      wr(`ADDR_SERIAL_PIN_ROUTING, 8'hff);
      rd_chk("routing", `ADDR_SERIAL_PIN_ROUTING, 8'h83);
      check("power down", {15'h0000, pd}, 16'h0001);
      $display("test registers done");
      // One row per rate source, two for the fixed rate; host bit time must match or bits shift
      for (int r = 0; r < 5; r++) begin
         c = (r == 4);
         nine <= (ctrl_t[r][7:6] != 2'b01);
         bits <= bits_t[r];
         wr(`ADDR_SERIAL_PIN_ROUTING, {7'h00, c});
         wr(`ADDR_POWER_AND_BAUD_DOUBLE, dbl_t[r]);
         wr(`ADDR_BAUD_SOURCE_CONTROL, src_t[r]);
         wr(c ? `ADDR_CH1_RELOAD_HIGH : `ADDR_CH0_RELOAD_HIGH, 8'h03);
         wr(c ? `ADDR_CH1_RELOAD_LOW : `ADDR_CH0_RELOAD_LOW, rel_t[r]);
         wr(c ? `ADDR_CH1_CONTROL : `ADDR_CH0_CONTROL, ctrl_t[r]);
         wr(c ? `ADDR_CH1_DATA : `ADDR_CH0_DATA, ctrl_t[r] ^ 8'ha5);
         wait_on(c);
         check("frame", {6'h00, got}, (ctrl_t[r][7:6] != 2'b01) ? {7'h01, ctrl_t[r][3], ctrl_t[r] ^ 8'ha5}
            : {8'h01, ctrl_t[r] ^ 8'ha5});
         check("vector", vec, c ? 16'h0083 : 16'h0023);
         wr(c ? `ADDR_CH1_CONTROL : `ADDR_CH0_CONTROL, ctrl_t[r]);
         @(posedge clock_in);
         check("cleared", {15'h0000, c ? irq1 : irq0}, 16'h0000);
         $display("test frame row %0d done", r);
      end
      nine <= 1'b1;
      wr(`ADDR_CH1_CONTROL, 8'h30);
      i_host.send_word(9'h0a5);
      check("multiproc", {15'h0000, irq1}, 16'h0000);
      nine <= 1'b0;
      bits <= 16'h0020;
      wr(`ADDR_CH1_CONTROL, 8'h90);
      i_host.send_word(9'h03c);
      wait_on(1);
      rd_chk("rx data", `ADDR_CH1_DATA, 8'h3c);
      rd_chk("rx control", `ADDR_CH1_CONTROL, 8'h95);
      check("vector", vec, 16'h0083);
      wr(`ADDR_CH1_CONTROL, 8'h00);
      $display("test receive done");
      loop_q <= 1'b1;
      wr(`ADDR_SERIAL_PIN_ROUTING, 8'h02);
      wr(`ADDR_POWER_AND_BAUD_DOUBLE, 8'h80);
      wr(`ADDR_CH1_CONTROL, 8'h10);
      wr(`ADDR_CH0_CONTROL, 8'h80);
      wr(`ADDR_CH0_DATA, 8'h5a);
      wait_on(1);
      rd_chk("loop data", `ADDR_CH1_DATA, 8'h5a);
      rd_chk("loop control", `ADDR_CH1_CONTROL, 8'h11);
      $display("test loopback done");
      loop_q <= 1'b0;
      wr(`ADDR_SERIAL_PIN_ROUTING, 8'h00);
      for (int i = 0; i < 6; i++)
         wr(`ADDR_CH0_DATA, 8'h10 + i[7:0]);
      check("fifo full", {15'h0000, fifo_rdy[0]}, 16'h0000);
      wait_on(2);
      $display("test fifo done");
      summarize();
   end
endmodule : tb_dual_uart
`default_nettype wire
